// ---- rtl/pcg_config_power.sv ----
// Configuration registers, base address, interrupt routing and
// clock gating for the serial and floppy functions.
// Assumes pulses from the floppy logic are one cycle long and
// synchronous to clk; the register port never waits.
`timescale 1ns/1ps
`default_nettype none
module pcg_config_power (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdData,
    input  wire logic [2:0]  strapPowerDown,
    input  wire logic        powerdownPinN,
    input  wire logic        floppyLowPowerCmd,
    input  wire logic        rateSelWr,
    input  wire logic [7:0]  rateSelData,
    input  wire logic        floppyOutWr,
    input  wire logic [7:0]  floppyOutData,
    input  wire logic        floppyStatusRd,
    input  wire logic        floppyDataRd,
    output logic [15:0]      parallelBase,
    output logic             parIrqSeven,
    output logic             uart1IrqFour,
    output logic             uart2IrqFour,
    output logic             uart1ClkEn,
    output logic             uart2ClkEn,
    output logic             floppyClkEn,
    output logic             reqMasterOk
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] fer_q, fer_d;
    logic [7:0] far_q, far_d;
    logic [7:0] ptr_q, ptr_d;
    logic [7:0] ppb_q, ppb_d;
    logic [7:0] plug_config_zero_q, plug_config_zero_d;
    logic [7:0] plug_config_one_q, plug_config_one_d;
    logic [2:0] strap_q;
    logic       dorReset_q;
    logic [7:0] regRdData_q;
    logic [15:0] parallelBase_q;
    logic       parIrqSeven_q, uart1IrqFour_q, uart2IrqFour_q;
    logic       uart1ClkEn_q, uart2ClkEn_q, floppyClkEn_q;
    logic       reqMasterOk_q;
    pcg_pkg::pcg_fstate_t fstate_q, fstate_d;
    logic [7:0] statusWord;
    localparam logic [7:0] RST_ZERO_L = pcg_pkg::RST_ZERO;

    // Write address match, used by every writable register
    function automatic logic hit(input logic [7:0] off);
        hit = regWr && (regAddr == off);
    endfunction

    // Base address from slot code, switch bit and register
    function automatic logic [15:0] baseOf(input logic [1:0] slot,
                                           input logic       sw,
                                           input logic [7:0] ppb);
        if (slot == pcg_pkg::SLOT_PRIMARY) begin
            baseOf = sw ? {6'h00, ppb, 2'h0}
                        : pcg_pkg::BASE_PRIMARY;
        end else if (slot == pcg_pkg::SLOT_THIRD) begin
            baseOf = pcg_pkg::BASE_THIRD;
        end else begin
            baseOf = pcg_pkg::BASE_SECOND;
        end
    endfunction

    // ------------------------------------------------------------
    // Next register values
    // ------------------------------------------------------------
    // Writes land on the next edge; derived outputs use these next values
    // so a write shows in the same edge it lands, except a strap lift, which reaches the clock enables one edge later.
    always_comb begin
        fer_d  = hit(pcg_pkg::OFF_FUNC_ENABLE)  ? regWrData : fer_q;
        far_d  = hit(pcg_pkg::OFF_FUNC_ADDRESS) ? regWrData : far_q;
        ptr_d  = hit(pcg_pkg::OFF_POWER_TEST)   ? regWrData : ptr_q;
        plug_config_zero_d = hit(pcg_pkg::OFF_PLUG_ZERO)
                 ? (regWrData & pcg_pkg::P0_MASK) : plug_config_zero_q;
        plug_config_one_d = hit(pcg_pkg::OFF_PLUG_ONE)
                 ? (regWrData & pcg_pkg::P1_MASK) : plug_config_one_q;
        // Base write accepted only once the switch bit is set
        if (!plug_config_zero_d[pcg_pkg::P0_BASESW]) begin
            ppb_d = pcg_pkg::PPB_FORCED;
        end else if (hit(pcg_pkg::OFF_PRINTER_BASE)) begin
            ppb_d = regWrData;
        end else begin
            ppb_d = ppb_q;
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            fer_q  <= pcg_pkg::RST_ZERO;
            far_q  <= pcg_pkg::RST_ZERO;
            ptr_q  <= pcg_pkg::RST_ZERO;
            plug_config_zero_q <= pcg_pkg::RST_ZERO;
            plug_config_one_q <= pcg_pkg::RST_ZERO;
            ppb_q  <= pcg_pkg::PPB_FORCED;
        end else begin
            fer_q  <= fer_d;
            far_q  <= far_d;
            ptr_q  <= ptr_d;
            plug_config_zero_q <= plug_config_zero_d;
            plug_config_one_q <= plug_config_one_d;
            ppb_q  <= ppb_d;
        end
    end

    // Strap power-down caught while reset is held; an enable
    // write of one for that function lifts it.
    always_ff @(posedge clk) begin
        if (rst) begin
            strap_q <= strapPowerDown;
        end else if (hit(pcg_pkg::OFF_FUNC_ENABLE)) begin
            strap_q <= strap_q & ~regWrData[3:1];
        end
    end

    // Read port: data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData_q <= RST_ZERO_L;
        end else if (regRd) begin
            case (regAddr)
                pcg_pkg::OFF_FUNC_ENABLE:  regRdData_q <= fer_q;
                pcg_pkg::OFF_FUNC_ADDRESS: regRdData_q <= far_q;
                pcg_pkg::OFF_POWER_TEST:   regRdData_q <= ptr_q;
                pcg_pkg::OFF_PRINTER_BASE: regRdData_q <= ppb_q;
                pcg_pkg::OFF_PLUG_ZERO:    regRdData_q <= plug_config_zero_q;
                pcg_pkg::OFF_PLUG_ONE:     regRdData_q <= plug_config_one_q;
                pcg_pkg::OFF_CLOCK_STATUS: regRdData_q <= statusWord;
                default:                   regRdData_q <= RST_ZERO_L;
            endcase
        end else begin
            regRdData_q <= RST_ZERO_L;
        end
    end

    // ------------------------------------------------------------
    // Base address and interrupt routing
    // ------------------------------------------------------------
    logic parIrqSevenC, uart1IrqFourC, uart2IrqFourC;

    pcg_irq_route uRoute (
        .funcAddr     (far_d[5:0]),
        .parIrqHint   (ptr_d[pcg_pkg::PT_PARIRQ]),
        .plugZero     (plug_config_zero_d),
        .plugOne      (plug_config_one_d),
        .parIrqSeven  (parIrqSevenC),
        .uart1IrqFour (uart1IrqFourC),
        .uart2IrqFour (uart2IrqFourC)
    );

    // Registered copies so every output leaves a flip-flop
    always_ff @(posedge clk) begin
        if (rst) begin
            parallelBase_q <= pcg_pkg::BASE_SECOND;
            parIrqSeven_q  <= 1'b0;
            uart1IrqFour_q <= 1'b1;
            uart2IrqFour_q <= 1'b1;
        end else begin
            parallelBase_q <= baseOf(far_d[1:0],
                plug_config_zero_d[pcg_pkg::P0_BASESW], ppb_d);
            parIrqSeven_q  <= parIrqSevenC;
            uart1IrqFour_q <= uart1IrqFourC;
            uart2IrqFour_q <= uart2IrqFourC;
        end
    end

    // ------------------------------------------------------------
    // Power-down conditions
    // ------------------------------------------------------------
    // The pin and power bit only count with the crystal source bit
    // clear; with it set they leave the crystal running, but the power bit still stops the function clocks.
    logic allOff, pinDown, bitDown, xtalOff, oscStable;
    assign allOff  = (fer_d[3:1] == 3'h0);
    assign pinDown = !ptr_d[pcg_pkg::PT_CLKSRC]
                     && !ptr_d[pcg_pkg::PT_CSPD]
                     && !powerdownPinN;
    assign bitDown = !ptr_d[pcg_pkg::PT_CLKSRC]
                     && ptr_d[pcg_pkg::PT_PWRDOWN];
    assign xtalOff = allOff || pinDown || bitDown;

    pcg_osc_settle uOsc (
        .clk       (clk),
        .rst       (rst),
        .oscRun    (!xtalOff),
        .oscStable (oscStable)
    );

    // Serial clocks: enabled, no power-down bit, no global stop
    logic [2:1] uartRun;
    genvar gi;
    generate
        for (gi = 1; gi <= 2; gi++) begin : gUart
            assign uartRun[gi] = fer_d[gi]
                && !ptr_d[pcg_pkg::PT_PWRDOWN]
                && !pinDown && !strap_q[gi-1];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            uart1ClkEn_q <= 1'b0;
            uart2ClkEn_q <= 1'b0;
        end else begin
            uart1ClkEn_q <= uartRun[1];
            uart2ClkEn_q <= uartRun[2];
        end
    end

    // ------------------------------------------------------------
    // Floppy clock state
    // ------------------------------------------------------------
    logic fdcCanRun, fdcStopReq, fdcWake, dorRise;
    assign fdcCanRun = fer_d[pcg_pkg::FE_FLOPPY]
                       && !ptr_d[pcg_pkg::PT_PWRDOWN]
                       && !pinDown && !strap_q[2];
    assign fdcStopReq = !fdcCanRun
        || (floppyLowPowerCmd && !ptr_d[pcg_pkg::PT_CLKSRC])
        || (rateSelWr && rateSelData[pcg_pkg::RS_LOWPWR]
            && !ptr_d[pcg_pkg::PT_CLKSRC]);
    assign dorRise = floppyOutWr && !dorReset_q
                     && floppyOutData[pcg_pkg::FO_RESET];
    assign fdcWake = floppyStatusRd || floppyDataRd || dorRise
        || (rateSelWr && rateSelData[pcg_pkg::RS_SWRESET]);

    // Last written reset bit of the floppy output register
    always_ff @(posedge clk) begin
        if (rst) begin
            dorReset_q <= 1'b0;
        end else if (floppyOutWr) begin
            dorReset_q <= floppyOutData[pcg_pkg::FO_RESET];
        end
    end

    // A stop request beats a wake access in the same cycle
    always_comb begin
        fstate_d = fstate_q;
        case (fstate_q)
            pcg_pkg::FPS_RUN: begin
                if (fdcStopReq) begin
                    fstate_d = pcg_pkg::FPS_STOP;
                end
            end
            pcg_pkg::FPS_STOP: begin
                if (!fdcStopReq && fdcWake) begin
                    fstate_d = pcg_pkg::FPS_WAKE;
                end
            end
            pcg_pkg::FPS_WAKE: begin
                if (fdcStopReq) begin
                    fstate_d = pcg_pkg::FPS_STOP;
                end else if (oscStable) begin
                    fstate_d = pcg_pkg::FPS_RUN;
                end
            end
            default: fstate_d = pcg_pkg::FPS_STOP;
        endcase
    end

    // Floppy starts stopped: it is disabled after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            fstate_q      <= pcg_pkg::FPS_STOP;
            floppyClkEn_q <= 1'b0;
            reqMasterOk_q <= 1'b0;
        end else begin
            fstate_q      <= fstate_d;
            floppyClkEn_q <= (fstate_d != pcg_pkg::FPS_STOP);
            reqMasterOk_q <= (fstate_d == pcg_pkg::FPS_RUN)
                             && oscStable;
        end
    end

    // Clock status word for software
    assign statusWord = {3'h0, oscStable, reqMasterOk_q,
                         floppyClkEn_q, uart2ClkEn_q, uart1ClkEn_q};

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign regRdData    = regRdData_q;
    assign parallelBase = parallelBase_q;
    assign parIrqSeven  = parIrqSeven_q;
    assign uart1IrqFour = uart1IrqFour_q;
    assign uart2IrqFour = uart2IrqFour_q;
    assign uart1ClkEn   = uart1ClkEn_q;
    assign uart2ClkEn   = uart2ClkEn_q;
    assign floppyClkEn  = floppyClkEn_q;
    assign reqMasterOk  = reqMasterOk_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_base_zero_bits: assert property (@(posedge clk) disable iff (rst)
        parallelBase[1:0] == 2'h0 && parallelBase[15:10] == 6'h00)
        else $error("base stray bits");
    chk_base_from_reg: assert property (@(posedge clk) disable iff (rst)
        far_q[1:0] == pcg_pkg::SLOT_PRIMARY && plug_config_zero_q[6]
        |-> parallelBase[9:2] == ppb_q) else $error("base not reg");
    chk_base_fixed: assert property (@(posedge clk) disable iff (rst)
        far_q[1:0] == pcg_pkg::SLOT_PRIMARY && !plug_config_zero_q[6]
        |-> parallelBase == 16'h03BC) else $error("primary not 3BC");
    chk_base_forced: assert property (@(posedge clk) disable iff (rst)
        !plug_config_zero_q[6] |-> ppb_q == 8'hEF) else $error("base not EF");
    chk_par_irq_map: assert property (@(posedge clk) disable iff (rst)
        plug_config_zero_q[4] |-> parIrqSeven == plug_config_zero_q[5])
        else $error("parallel irq map");
    chk_uart1_map: assert property (@(posedge clk) disable iff (rst)
        plug_config_one_q[0] |-> uart1IrqFour == plug_config_one_q[2])
        else $error("serial one irq map");
    chk_uart2_map: assert property (@(posedge clk) disable iff (rst)
        plug_config_one_q[0] |-> uart2IrqFour == plug_config_one_q[6])
        else $error("serial two irq map");
    chk_uart_legacy: assert property (@(posedge clk) disable iff (rst)
        !plug_config_one_q[0] |-> uart1IrqFour == !far_q[2])
        else $error("serial legacy map");
    chk_reset_clear: assert property (@(posedge clk)
        $fell(rst) |-> plug_config_zero_q == 8'h00 && plug_config_one_q == 8'h00)
        else $error("plug regs not clear");
    chk_uart_restore: assert property (@(posedge clk) disable iff (rst)
        uart1ClkEn |-> fer_q[1] && !ptr_q[0])
        else $error("serial clock early");
    chk_disabled_off: assert property (@(posedge clk) disable iff (rst)
        !fer_q[3] |-> !floppyClkEn) else $error("floppy clock on");
    chk_rate_stop: assert property (@(posedge clk) disable iff (rst)
        rateSelWr && rateSelData[6] && !ptr_q[1] |=> !floppyClkEn)
        else $error("rate bit no stop");
    chk_all_stop: assert property (@(posedge clk) disable iff (rst)
        ptr_q[0] && !ptr_q[1]
        |-> !uart1ClkEn && !uart2ClkEn && !floppyClkEn)
        else $error("power bit no stop");
    chk_rqm_hold: assert property (@(posedge clk) disable iff (rst)
        reqMasterOk |-> $past(oscStable))
        else $error("master before settle");
endmodule
`default_nettype wire

// ---- rtl/pcg_irq_route.sv ----
// Interrupt routing for the parallel port and both serial ports.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
module pcg_irq_route (
    input  wire logic [5:0] funcAddr,
    input  wire logic       parIrqHint,
    input  wire logic [7:0] plugZero,
    input  wire logic [7:0] plugOne,
    output logic            parIrqSeven,
    output logic            uart1IrqFour,
    output logic            uart2IrqFour
);
    // ------------------------------------------------------------
    // Legacy or programmed selection
    // ------------------------------------------------------------
    // Legacy: primary slot or power test hint picks the high line
    always_comb begin
        if (plugZero[pcg_pkg::P0_PARSEL]) begin
            parIrqSeven = plugZero[pcg_pkg::P0_PARMAP];
        end else begin
            parIrqSeven = (funcAddr[1:0] == pcg_pkg::SLOT_PRIMARY)
                          | parIrqHint;
        end
    end

    // Legacy: even serial slots sit on the high line
    always_comb begin
        if (plugOne[pcg_pkg::P1_UARTSEL]) begin
            uart1IrqFour = plugOne[pcg_pkg::P1_U1MAP];
            uart2IrqFour = plugOne[pcg_pkg::P1_U2MAP];
        end else begin
            uart1IrqFour = ~funcAddr[2];
            uart2IrqFour = ~funcAddr[4];
        end
    end
endmodule
`default_nettype wire

// ---- rtl/pcg_osc_settle.sv ----
// Oscillator settling timer: flags the crystal as stable once it
// has run without a break for the settling time.
// Assumes oscRun drops whenever the crystal is stopped.
`timescale 1ns/1ps
`default_nettype none
module pcg_osc_settle (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic oscRun,
    output logic      oscStable
);
    localparam logic [15:0] SETTLE =
        16'(pcg_pkg::OSC_SETTLE_CYC);

    logic [15:0] count_q;
    logic        stable_q;

    // Count run time; any stop restarts the wait
    always_ff @(posedge clk) begin
        if (rst || !oscRun) begin
            count_q  <= 16'h0000;
            stable_q <= 1'b0;
        end else if (count_q != SETTLE) begin
            count_q  <= count_q + 16'h0001;
        end else begin
            stable_q <= 1'b1;
        end
    end

    assign oscStable = stable_q;

    chk_stop_clears: assert property (@(posedge clk) disable iff (rst)
        !oscRun |=> !oscStable) else $error("stable after stop");
    chk_settle_wait: assert property (@(posedge clk) disable iff (rst)
        $rose(oscStable) |-> count_q == SETTLE)
        else $error("stable too early");
endmodule
`default_nettype wire

// ---- rtl/pcg_pkg.sv ----
// Constants for the configuration and clock gating block.
// Assumes one 125 MHz clock and an 8-bit indexed register port.
package pcg_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_FUNC_ENABLE  = 8'h00;
    localparam logic [7:0] OFF_FUNC_ADDRESS = 8'h01;
    localparam logic [7:0] OFF_POWER_TEST   = 8'h02;
    localparam logic [7:0] OFF_PRINTER_BASE = 8'h19;
    localparam logic [7:0] OFF_PLUG_ZERO    = 8'h1B;
    localparam logic [7:0] OFF_PLUG_ONE     = 8'h1C;
    localparam logic [7:0] OFF_CLOCK_STATUS = 8'h1D;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FE_PARALLEL = 0;
    localparam int FE_UART1    = 1;
    localparam int FE_UART2    = 2;
    localparam int FE_FLOPPY   = 3;
    localparam int PT_PWRDOWN  = 0;
    localparam int PT_CLKSRC   = 1;
    localparam int PT_CSPD     = 2;
    localparam int PT_PARIRQ   = 3;
    localparam int P0_PARSEL   = 4;
    localparam int P0_PARMAP   = 5;
    localparam int P0_BASESW   = 6;
    localparam int P1_UARTSEL  = 0;
    localparam int P1_U1MAP    = 2;
    localparam int P1_U2MAP    = 6;
    localparam int RS_LOWPWR   = 6;
    localparam int RS_SWRESET  = 7;
    localparam int FO_RESET    = 2;

    // Implemented bits of the plug-and-play registers
    localparam logic [7:0] P0_MASK = 8'h70;
    localparam logic [7:0] P1_MASK = 8'h45;

    // ------------------------------------------------------------
    // Values after reset and fixed addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_ZERO      = 8'h00;
    localparam logic [7:0]  PPB_FORCED    = 8'hEF;
    localparam logic [1:0]  SLOT_PRIMARY  = 2'h1;
    localparam logic [1:0]  SLOT_THIRD    = 2'h2;
    localparam logic [15:0] BASE_PRIMARY  = 16'h03BC;
    localparam logic [15:0] BASE_SECOND   = 16'h0378;
    localparam logic [15:0] BASE_THIRD    = 16'h0278;

    // ------------------------------------------------------------
    // Oscillator settling time
    // ------------------------------------------------------------
    localparam int OSC_SETTLE_NS  = 2000;
    localparam int CLK_PERIOD_NS  = 8;
    localparam int OSC_SETTLE_CYC =
        (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Floppy clock state, Gray coded along run, stop, wake
    typedef enum logic [1:0] {
        FPS_RUN  = 2'b00,
        FPS_STOP = 2'b01,
        FPS_WAKE = 2'b11
    } pcg_fstate_t;
endpackage

// ---- testbench/pnp_config_and_power_gating_test.sv ----
// Self-checking bench for the configuration and clock gating block.
// Assumes one clock, the register port answering one cycle after a read.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin nChecks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module pnp_config_and_power_gating_test;
    logic        clk, rst, regWr, regRd, powerdownPinN, floppyLowPowerCmd;
    logic        rateSelWr, floppyOutWr, floppyStatusRd, floppyDataRd;
    logic [7:0]  regAddr, regWrData, rateSelData, floppyOutData, regRdData;
    logic [2:0]  strapPowerDown;
    logic [15:0] parallelBase;
    logic        parIrqSeven, uart1IrqFour, uart2IrqFour, reqMasterOk;
    logic        uart1ClkEn, uart2ClkEn, floppyClkEn;
    int          fails, nChecks, cyc, w;

    pcg_config_power dut_u (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .strapPowerDown(strapPowerDown),
        .powerdownPinN(powerdownPinN), .floppyLowPowerCmd(floppyLowPowerCmd),
        .rateSelWr(rateSelWr), .rateSelData(rateSelData),
        .floppyOutWr(floppyOutWr), .floppyOutData(floppyOutData),
        .floppyStatusRd(floppyStatusRd), .floppyDataRd(floppyDataRd),
        .parallelBase(parallelBase), .parIrqSeven(parIrqSeven),
        .uart1IrqFour(uart1IrqFour), .uart2IrqFour(uart2IrqFour),
        .uart1ClkEn(uart1ClkEn), .uart2ClkEn(uart2ClkEn),
        .floppyClkEn(floppyClkEn), .reqMasterOk(reqMasterOk));

    // ------------------------------------------------------------
    // Clock, hang guard and verdict
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Whole run is well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end

    task automatic results();
        if (fails == 0 && nChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Register port and floppy pulse tasks
    // ------------------------------------------------------------
    // Idle cycle between accesses keeps each strobe a clean pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        `CHK("rdata", e, regRdData)
    endtask

    // Pulse bits: output write, data read, low power, rate, status
    task automatic fp(input logic [4:0] p, input logic [7:0] r);
        @(posedge clk);
        {floppyOutWr, floppyDataRd, floppyLowPowerCmd, rateSelWr,
            floppyStatusRd} <= p;
        rateSelData <= r;
        floppyOutData <= r;
        @(posedge clk);
        {floppyOutWr, floppyDataRd, floppyLowPowerCmd, rateSelWr,
            floppyStatusRd} <= 5'h00;
        #1;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, regWr, regRd, floppyLowPowerCmd, rateSelWr} = 5'h10;
        {floppyOutWr, floppyStatusRd, floppyDataRd} = 3'h0;
        {regAddr, regWrData, rateSelData, floppyOutData} = 32'h0;
        {strapPowerDown, powerdownPinN} = 4'h1;
        {fails, nChecks, cyc} = 96'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(8'h19, 8'hEF);
        rd(8'h1B, 8'h00);
        rd(8'h1C, 8'h00);
        rd(8'h05, 8'h00);
        wr(8'h01, 8'h01);
        `CHK("base", 16'h03BC, parallelBase)
        wr(8'h19, 8'h55);
        rd(8'h19, 8'hEF);
        wr(8'h1B, 8'hFF);
        rd(8'h1B, 8'h70);
        `CHK("irq7", 1'b1, parIrqSeven)
        wr(8'h19, 8'h55);
        `CHK("base", 16'h0154, parallelBase)
        rd(8'h19, 8'h55);
        wr(8'h01, 8'h02);
        `CHK("base", 16'h0278, parallelBase)
        // Second slot with no hint bit gives line five in legacy mode
        wr(8'h01, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(8'h1B, {2'h0, k[1:0], 4'h0});
            `CHK("irq7", k[0] ? k[1] : 1'b0, parIrqSeven)
        end
        wr(8'h02, 8'h08);
        wr(8'h1B, 8'h20);
        `CHK("irq7", 1'b1, parIrqSeven)
        wr(8'h02, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(8'h1C, {1'b0, k[2], 3'h0, k[1], 1'b0, k[0]});
            `CHK("irq4a", k[0] ? k[1] : 1'b1, uart1IrqFour)
            `CHK("irq4b", k[0] ? k[2] : 1'b1, uart2IrqFour)
        end
        wr(8'h1C, 8'hFF);
        rd(8'h1C, 8'h45);
        wr(8'h00, 8'h06);
        `CHK("clks", 3'h3, {floppyClkEn, uart2ClkEn, uart1ClkEn})
        wr(8'h02, 8'h01);
        `CHK("clks", 3'h0, {floppyClkEn, uart2ClkEn, uart1ClkEn})
        wr(8'h02, 8'h00);
        wr(8'h00, 8'h0C);
        `CHK("clks", 3'h2, {floppyClkEn, uart2ClkEn, uart1ClkEn})
        fp(3'h1, 8'h00);
        `CHK("fclk", 1'b1, floppyClkEn)
        `CHK("rqm", 1'b0, reqMasterOk)
        w = 0;
        while (reqMasterOk !== 1'b1 && w < 400) begin
            @(posedge clk);
            #1;
            w++;
        end
        `CHK("settle", 1'b1, w > 200 && w < 400)
        rd(8'h1D, 8'h1E);
        fp(3'h4, 8'h00);
        `CHK("fclk", 1'b0, floppyClkEn)
        fp(3'h2, 8'h80);
        `CHK("fclk", 1'b1, floppyClkEn)
        fp(3'h2, 8'h40);
        `CHK("fclk", 1'b0, floppyClkEn)
        // Output reset bit rising wakes; a repeated one does not
        fp(5'h10, 8'h04);
        `CHK("fclk", 1'b1, floppyClkEn)
        fp(5'h04, 8'h00);
        fp(5'h10, 8'h04);
        `CHK("fclk", 1'b0, floppyClkEn)
        fp(5'h08, 8'h00);
        `CHK("fclk", 1'b1, floppyClkEn)
        fp(3'h1, 8'h00);
        @(posedge clk);
        powerdownPinN <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("clks", 3'h0, {floppyClkEn, uart2ClkEn, uart1ClkEn})
        results();
    end
endmodule
`default_nettype wire
